// File: edsp_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - Processor enable resets to zero; must stay set while any enhancement is on.
// - Writing one to exec bit 2 halts the enhancement processor.
// - Writing one to exec bit 1 starts the enhancement processor.
// - Record high-pass active by default; bypass bit disables it.
// - Hi-fi mode: first-order DC removal, 3.5Hz cutoff at 44.1kHz.
// - Application mode takes cutoff from three-bit field; host keeps below 300Hz.
// - Playback high-pass stays off unless a record EQ, playback EQ, bass boost or surround enable is set.
// - Order select: 0 first-order hi-fi, 1 second-order application.
module edsp_ctrl (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Register port
	input wire logic [15:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	// Processor control
	output logic proc_on_o,
	output logic proc_running_o,
	output logic halt_pulse_o,
	output logic go_pulse_o,
	// Enhancement enables as applied to the datapath
	output logic rec_eq_on_o,
	output logic play_eq_on_o,
	output logic bass_boost_on_o,
	output logic play_hp_a_on_o,
	output logic play_hp_b_on_o,
	output logic surround_on_o,
	// Record high-pass control
	output logic rec_hp_active_o,
	output logic rec_hp_second_order_o,
	output logic [2:0] rec_hp_cutoff_o,
	output logic [1:0] rec_hp_band_o
);

	typedef struct packed {
		logic [15:0] rdata;
		logic proc_on;
		logic running;
		logic halt;
		logic go;
		logic [5:0] enh;
		logic [5:0] enh_out;
		logic bypass;
		logic order;
		logic [2:0] cut;
		logic [1:0] band;
	} edsp_state_t;

	edsp_state_t state;
	edsp_state_t next_state;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [5:0] e;
		logic others;
		e = 6'h00;
		others = 1'b0;
		next_state = state;
		next_state.halt = 1'b0;
		next_state.go = 1'b0;
		next_state.rdata = 16'h0000;
		if (wr_i) begin
			unique case (addr_i)
				edsp_pkg::OFS_POWER: begin
					next_state.proc_on = wdata_i[edsp_pkg::BIT_PROC_ON];
				end
				edsp_pkg::OFS_EXEC: begin
					next_state.halt = wdata_i[edsp_pkg::BIT_HALT];
					next_state.go = wdata_i[edsp_pkg::BIT_GO];
				end
				edsp_pkg::OFS_ENH_ENA: begin
					next_state.enh = wdata_i[5:0];
				end
				edsp_pkg::OFS_ADC_CTL1: begin
					next_state.bypass = wdata_i[edsp_pkg::BIT_HP_BYPASS];
				end
				edsp_pkg::OFS_ADC_CTL2: begin
					next_state.order = wdata_i[edsp_pkg::BIT_HP_ORDER];
					next_state.cut = wdata_i[edsp_pkg::BIT_CUT_LO +: 3];
					next_state.band = wdata_i[edsp_pkg::BIT_BAND_LO +: 2];
				end
				default: begin
				end
			endcase
		end
		// Halt wins over go if both are written together
		if (next_state.halt) begin
			next_state.running = 1'b0;
		end else if (next_state.go) begin
			next_state.running = 1'b1;
		end
		// Enhancements only reach the datapath while the processor is enabled
		e = next_state.enh & {6{next_state.proc_on}};
		others = e[edsp_pkg::BIT_REC_EQ] | e[edsp_pkg::BIT_PLAY_EQ] |
			e[edsp_pkg::BIT_BASS] | e[edsp_pkg::BIT_SURR];
		e[edsp_pkg::BIT_HPA] = e[edsp_pkg::BIT_HPA] & others;
		e[edsp_pkg::BIT_HPB] = e[edsp_pkg::BIT_HPB] & others;
		next_state.enh_out = e;
		if (rd_i) begin
			unique case (addr_i)
				edsp_pkg::OFS_POWER: begin
					next_state.rdata[edsp_pkg::BIT_PROC_ON] = state.proc_on;
				end
				edsp_pkg::OFS_ENH_ENA: begin
					next_state.rdata[5:0] = state.enh;
				end
				edsp_pkg::OFS_ADC_CTL1: begin
					next_state.rdata[edsp_pkg::BIT_HP_BYPASS] = state.bypass;
				end
				edsp_pkg::OFS_ADC_CTL2: begin
					next_state.rdata[edsp_pkg::BIT_HP_ORDER] = state.order;
					next_state.rdata[edsp_pkg::BIT_CUT_LO +: 3] = state.cut;
					next_state.rdata[edsp_pkg::BIT_BAND_LO +: 2] = state.band;
				end
				edsp_pkg::OFS_STATUS: begin
					next_state.rdata[0] = state.running;
					next_state.rdata[6:1] = state.enh_out;
				end
				default: begin
					// Exec register and unmapped addresses read zero
					next_state.rdata = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state <= '0;
			state.proc_on <= edsp_pkg::RST_PROC_ON;
			state.enh <= edsp_pkg::RST_ENH;
			state.enh_out <= edsp_pkg::RST_ENH;
			state.bypass <= edsp_pkg::RST_BYPASS;
			state.order <= edsp_pkg::RST_ORDER;
			state.cut <= edsp_pkg::RST_CUT;
			state.band <= edsp_pkg::RST_BAND;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign rdata_o = state.rdata;
	assign proc_on_o = state.proc_on;
	assign proc_running_o = state.running;
	assign halt_pulse_o = state.halt;
	assign go_pulse_o = state.go;
	assign rec_eq_on_o = state.enh_out[edsp_pkg::BIT_REC_EQ];
	assign play_eq_on_o = state.enh_out[edsp_pkg::BIT_PLAY_EQ];
	assign bass_boost_on_o = state.enh_out[edsp_pkg::BIT_BASS];
	assign play_hp_a_on_o = state.enh_out[edsp_pkg::BIT_HPA];
	assign play_hp_b_on_o = state.enh_out[edsp_pkg::BIT_HPB];
	assign surround_on_o = state.enh_out[edsp_pkg::BIT_SURR];
	assign rec_hp_active_o = ~state.bypass;
	// Order 0 is the fixed hi-fi DC-removal filter
	assign rec_hp_second_order_o = state.order;
	assign rec_hp_cutoff_o = state.cut;
	assign rec_hp_band_o = state.band;

endmodule // edsp_ctrl

// File: edsp_pkg.sv
package edsp_pkg;
	// Register byte offsets on the control port
	localparam logic [15:0] OFS_POWER = 16'h0300;
	localparam logic [15:0] OFS_EXEC = 16'h040d;
	localparam logic [15:0] OFS_ENH_ENA = 16'h4005;
	localparam logic [15:0] OFS_ADC_CTL1 = 16'h0005;
	localparam logic [15:0] OFS_ADC_CTL2 = 16'h0006;
	localparam logic [15:0] OFS_STATUS = 16'h0310;
	// Field positions
	localparam int BIT_PROC_ON = 0;
	localparam int BIT_GO = 1;
	localparam int BIT_HALT = 2;
	localparam int BIT_REC_EQ = 0;
	localparam int BIT_PLAY_EQ = 1;
	localparam int BIT_BASS = 2;
	localparam int BIT_HPA = 3;
	localparam int BIT_HPB = 4;
	localparam int BIT_SURR = 5;
	localparam int BIT_HP_BYPASS = 0;
	localparam int BIT_HP_ORDER = 10;
	localparam int BIT_CUT_LO = 7;
	localparam int BIT_BAND_LO = 12;
	// Reset values
	localparam logic RST_PROC_ON = 1'b0;
	localparam logic [5:0] RST_ENH = 6'h00;
	localparam logic RST_BYPASS = 1'b0;
	localparam logic RST_ORDER = 1'b0;
	localparam logic [2:0] RST_CUT = 3'h0;
	localparam logic [1:0] RST_BAND = 2'h2;
endpackage

// File: edsp_host.sv
`timescale 1ns/1ps
module edsp_host (
	// Bus toward the block
	input wire logic clk_i,
	input wire logic [15:0] rdata_i,
	output logic [15:0] addr_o,
	output logic [15:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	initial {addr_o, wdata_o, wr_o, rd_o} = '0;
	// Data lines carry the inverse once released, so stale values cannot pass
	task automatic wr(input logic [15:0] a, d);
		@(posedge clk_i);
		{addr_o, wdata_o, wr_o} <= {a, d, 1'b1};
		@(posedge clk_i);
		{wdata_o, wr_o} <= {~d, 1'b0};
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk_i);
		{addr_o, rd_o} <= {a, 1'b1};
		@(posedge clk_i);
		rd_o <= 1'b0;
		// Read data stand only in the cycle after the strobe edge
		#1;
		d = rdata_i;
	endtask
endmodule // edsp_host

// File: edsp_chk.sv
`timescale 1ns/1ps
module edsp_chk (
	// Watched ports
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	input wire logic proc_on_o,
	input wire logic proc_running_o,
	input wire logic halt_pulse_o,
	input wire logic go_pulse_o,
	input wire logic rec_eq_on_o,
	input wire logic play_eq_on_o,
	input wire logic bass_boost_on_o,
	input wire logic play_hp_a_on_o,
	input wire logic play_hp_b_on_o,
	input wire logic surround_on_o,
	input wire logic rec_hp_active_o,
	input wire logic rec_hp_second_order_o,
	input wire logic [2:0] rec_hp_cutoff_o,
	input wire logic [1:0] rec_hp_band_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	wire ex = wr_i && addr_i == edsp_pkg::OFS_EXEC;
	wire oth = rec_eq_on_o || play_eq_on_o || bass_boost_on_o || surround_on_o;
	sequence s_go; ex && wdata_i[1] && !wdata_i[2]; endsequence
	sequence s_halt; ex && wdata_i[2]; endsequence
	go_run_a: assert property (s_go |=> go_pulse_o && proc_running_o) else $error("go lost");
	halt_stop_a: assert property (s_halt |=> halt_pulse_o && !proc_running_o) else $error("halt lost");
	cmd_quiet_a: assert property (!ex |=> !go_pulse_o && !halt_pulse_o) else $error("stray pulse");
	cmd_read_a: assert property (rd_i && addr_i == edsp_pkg::OFS_EXEC |=>
		rdata_o == 16'h0000) else $error("command bits read nonzero");
	proc_read_a: assert property (rd_i && addr_i == edsp_pkg::OFS_POWER |=>
		rdata_o == {15'h0000, $past(proc_on_o)}) else $error("power readback");
	enh_gate_a: assert property (oth |-> proc_on_o) else $error("enable without processor");
	hp_gate_a: assert property (play_hp_a_on_o |-> oth) else $error("lone high-pass");
	hp_b_gate_a: assert property (play_hp_b_on_o |-> oth) else $error("lone high-pass b");
	bypass_sel_a: assert property (wr_i && addr_i == edsp_pkg::OFS_ADC_CTL1 |=>
		rec_hp_active_o != $past(wdata_i[0])) else $error("bypass");
	hp_mode_a: assert property (wr_i && addr_i == edsp_pkg::OFS_ADC_CTL2 |=>
		rec_hp_second_order_o == $past(wdata_i[10]) && rec_hp_cutoff_o == $past(wdata_i[9:7])
		&& rec_hp_band_o == $past(wdata_i[13:12])) else $error("mode or cutoff");
endmodule // edsp_chk
bind edsp_ctrl edsp_chk edsp_chk_inst (.*);

// File: edsp_ctrl_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin miscompares++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module edsp_ctrl_tb_top;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [15:0] addr_i, wdata_i, rdata_o, v;
	logic wr_i, rd_i, proc_on_o, run, halt, go, act, ord;
	logic [5:0] enh;
	logic [2:0] cut;
	logic [1:0] band;
	int miscompares = 0;
	int checks = 0;
	always #2.5 clk_i = ~clk_i;
	edsp_ctrl edsp_ctrl_inst (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.proc_on_o, .proc_running_o(run), .halt_pulse_o(halt), .go_pulse_o(go),
		.rec_eq_on_o(enh[0]), .play_eq_on_o(enh[1]), .bass_boost_on_o(enh[2]),
		.play_hp_a_on_o(enh[3]), .play_hp_b_on_o(enh[4]), .surround_on_o(enh[5]),
		.rec_hp_active_o(act), .rec_hp_second_order_o(ord), .rec_hp_cutoff_o(cut),
		.rec_hp_band_o(band));
	edsp_host edsp_host_inst (.clk_i, .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i),
		.wr_o(wr_i), .rd_o(rd_i));
	task automatic wr(input logic [15:0] a, d);
		edsp_host_inst.wr(a, d);
		#1;
	endtask
	task automatic give_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic t_update_off;
		`CHK("proc_on", 1'b0, proc_on_o)
		`CHK("band", 2'h2, band)
		wr(16'h0015, 16'h0000); // (bench clock stands in for a fast master clock)
		wr(edsp_pkg::OFS_POWER, 16'h0001);
		wr(16'h4200, 16'h00a5);
		edsp_host_inst.rd(16'h4200, v);
		`CHK("unmapped", 16'h0000, v)
		edsp_host_inst.rd(edsp_pkg::OFS_POWER, v);
		`CHK("power", 16'h0001, v)
		$display("update test done");
	endtask
	task automatic t_run_stop;
		wr(edsp_pkg::OFS_EXEC, 16'h0002);
		`CHK("go", 2'h3, {go, run})
		@(posedge clk_i);
		#1;
		`CHK("go_once", 1'b0, go)
		wr(edsp_pkg::OFS_ENH_ENA, 16'h0008);
		`CHK("hp_alone", 6'h00, enh)
		wr(edsp_pkg::OFS_ENH_ENA, 16'h000c);
		`CHK("hp_bass", 6'h0c, enh)
		edsp_host_inst.rd(edsp_pkg::OFS_STATUS, v);
		`CHK("status", 16'h0019, v)
		edsp_host_inst.rd(edsp_pkg::OFS_EXEC, v);
		`CHK("exec_rd", 16'h0000, v)
		wr(edsp_pkg::OFS_ENH_ENA, 16'h0000);
		wr(edsp_pkg::OFS_EXEC, 16'h0004);
		`CHK("halt", 3'h4, {halt, run, go})
		wr(edsp_pkg::OFS_POWER, 16'h0000);
		`CHK("off", 1'b0, proc_on_o)
		$display("run stop test done");
	endtask
	task automatic t_hpf;
		`CHK("hp_dflt", 2'h2, {act, ord})
		wr(edsp_pkg::OFS_ADC_CTL1, 16'h0001);
		`CHK("bypass", 1'b0, act)
		wr(edsp_pkg::OFS_ADC_CTL2, 16'h1680);
		`CHK("mode", 6'h35, {ord, cut, band})
		$display("filter test done");
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		#1;
		t_update_off();
		t_run_stop();
		t_hpf();
		give_verdict();
	end
	initial begin
		repeat (5000) @(posedge clk_i);
		miscompares++;
		give_verdict();
	end
endmodule // edsp_ctrl_tb_top
